// file: verif/tb.sv
// self-checking bench for the valley / protection sequencer
`timescale 1ns/100ps
module tb;
  // ----------------------------------------------------------------
  // shortened counts so every long timer fits in one run
  // ----------------------------------------------------------------
  localparam int T_OUT = 30;
  localparam int MIN_OFF = 60;
  localparam int START = 80;
  localparam int OUTPUT_UNDERVOLTAGE_FAULT = 400;
  localparam int PAUSE = 150;
  localparam int BO = 100;
  localparam int LREL = 200;
  localparam int REC = 300;
  localparam int DEAD = 100;
  localparam int MAX_ON = 40;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic vs, bsd, a1, a115, b105, a2, strb, peak, c895, c913;
  logic bon, boff, lovp, lrel, drv, ffe, stby, red, uvf, ovf;
  logic damped = 1'b0;
  logic [7:0] on_len = 8'h08;
  logic [7:0] ring_len = 8'h0a;
  logic [15:0] dt = 16'h0064;
  logic [9:0] mon = 10'h028;
  int miscompares = 0, tests_run = 0;
  int cyc_n = 0, pulses = 0, strobes = 0, run_n = 0, last_off = 0;
  int last_on = 0, uv_at = 0, ov_str = 0;
  logic drv_q = 1'b0;
  initial begin
    {bsd, a1, a115, b105, a2, c895, lovp, lrel, boff} = '0;
    {c913, bon} = 2'b11;
  end
  always #25 clock = ~clock;
  vdps_core #(.RECOVER_CYC(REC), .LOVP_RST_CYC(LREL), .UVP_CYC(OUTPUT_UNDERVOLTAGE_FAULT),
    .BO_OFF_CYC(BO), .STARTUP_CYC(START), .SOVP_PAUSE_CYC(PAUSE),
    .MIN_OFF_CYC(MIN_OFF), .TIMEOUT_CYC(T_OUT)) i_dut (
    .clock(clock), .rst(rst), .valley_sense_input(vs),
    .below_short_detect(bsd), .above_first_ovp(a1), .above_115(a115),
    .below_105(b105), .above_second_ovp(a2), .sample_strobe(strb),
    .peak_reached(peak), .comp_below_895(c895), .comp_above_913(c913),
    .dead_time_cycles(dt), .max_on_cycles(mon), .above_brownout_on(bon),
    .below_brownout_off(boff), .above_line_ovp(lovp),
    .below_line_release(lrel), .gate_drive_output(drv),
    .feedforward_enable(ffe), .standby_active(stby),
    .reduced_setpoint(red), .output_undervoltage_fault(uvf),
    .overvoltage_fault(ovf));
  vdps_stage_model i_stage (.clock(clock), .damped(damped),
    .on_len(on_len), .ring_len(ring_len), .gate_drive_output(drv),
    .valley_sense_input(vs), .peak_reached(peak), .sample_strobe(strb));
  // ----------------------------------------------------------------
  // compare and wait helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi,
    input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // bounded wait for the next drive rise
  task automatic wait_rise(input int limit);
    int p;
    int n;
    p = pulses;
    n = 0;
    while (pulses == p && n < limit) begin
      @(posedge clock);
      n++;
    end
    chk_rng("cycles to next drive pulse", 0, limit - 1, n);
  endtask
  // no drive pulse may start for n cycles
  task automatic quiet(input int n);
    int p;
    p = pulses;
    cyc(n);
    chk_rng("drive pulses while held off", p, p, pulses);
  endtask
  // ----------------------------------------------------------------
  // event monitor, sampled on the falling edge where all has settled
  // ----------------------------------------------------------------
  always @(negedge clock) begin
    cyc_n++;
    if (strb) strobes++;
    if (uvf) uv_at = cyc_n;
    if (ovf && ov_str < 0) ov_str = strobes;
    chk("feed-forward follows on-time", drv, ffe);
    if (drv != drv_q) begin
      if (drv) begin
        pulses++;
        last_off = run_n;
      end else begin
        last_on = run_n;
      end
      run_n = 0;
    end
    run_n++;
    drv_q = drv;
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_start;
    cyc(2);
    chk("drive held in reset", 1'b0, drv);
    rst <= 1'b0;
    wait_rise(T_OUT + 10);
    $display("test start done");
  endtask
  task automatic t_switch;
    wait_rise(T_OUT);
    wait_rise(T_OUT);
    chk_rng("valley off-time", 10, 15, last_off);
    chk_rng("peak on-time", 8, 12, last_on);
    damped <= 1'b1;
    wait_rise(T_OUT + 20);
    wait_rise(T_OUT + 20);
    chk_rng("time-out off-time", T_OUT - 1, T_OUT + 4, last_off);
    on_len <= 8'h00;
    wait_rise(T_OUT + 60);
    wait_rise(T_OUT + 60);
    chk_rng("max on-time", MAX_ON - 1, MAX_ON + 3, last_on);
    {damped, on_len} <= {1'b0, 8'h08};
    $display("test switching done");
  endtask
  task automatic t_short;
    int t0;
    t0 = cyc_n;
    {bsd, damped} <= 2'b11;
    wait_rise(T_OUT + 20);
    wait_rise(T_OUT + 20);
    chk_rng("off-time before 8 ms", 0, MIN_OFF - 5, last_off);
    cyc(START + 10);
    wait_rise(MIN_OFF + 20);
    wait_rise(MIN_OFF + 20);
    chk_rng("minimum off-time", MIN_OFF, MIN_OFF + 10, last_off);
    cyc(OUTPUT_UNDERVOLTAGE_FAULT - (cyc_n - t0) + 6);
    chk_rng("under-voltage delay", OUTPUT_UNDERVOLTAGE_FAULT - 1, OUTPUT_UNDERVOLTAGE_FAULT + 5, uv_at - t0);
    bsd <= 1'b0; // lets the 8 ms timer clear during recovery
    quiet(REC - 20);
    bsd <= 1'b1;
    quiet(60);
    wait_rise(MIN_OFF + 20);
    wait_rise(MIN_OFF + 20);
    chk_rng("off-time after restart", MIN_OFF, MIN_OFF + 10, last_off);
    {bsd, damped} <= 2'b00;
    $display("test short done");
  endtask
  // fast trip: count samples from set to fault
  task automatic fast_trip(input int n);
    int s0;
    int k;
    wait_rise(T_OUT + PAUSE + 20);
    a2 <= 1'b1;
    s0 = strobes;
    ov_str = -1;
    k = 0;
    // stop at the first trip so a restart cannot trip a second time
    while (ov_str < 0 && k < PAUSE * n) begin
      @(posedge clock);
      k++;
    end
    a2 <= 1'b0;
    chk_rng("samples to fast trip", n, n, ov_str - s0);
    quiet(REC - 10);
    wait_rise(100);
  endtask
  task automatic t_ovp;
    fast_trip(4);
    {a1, a115} <= 2'b11;
    cyc(100);
    chk("reduced setpoint in slow trip", 1'b1, red);
    wait_rise(PAUSE + 20);
    wait_rise(PAUSE + 20);
    chk_rng("slow pause", PAUSE - 2, PAUSE + 12, last_off);
    {a115, b105} <= 2'b01;
    wait_rise(PAUSE + 20);
    cyc(20);
    chk("normal after release", 1'b0, red);
    {a1, b105} <= 2'b00;
    fast_trip(2);
    $display("test overvoltage done");
  endtask
  task automatic t_line;
    {bon, boff} <= 2'b01;
    cyc(BO - 40);
    wait_rise(30);
    cyc(50);
    quiet(100);
    {bon, boff} <= 2'b10;
    wait_rise(T_OUT + 20);
    lovp <= 1'b1;
    cyc(3);
    quiet(100);
    {lovp, lrel} <= 2'b01;
    quiet(LREL - 20);
    wait_rise(T_OUT + 60);
    lrel <= 1'b0;
    $display("test line done");
  endtask
  task automatic t_standby;
    {c895, c913} <= 2'b10;
    cyc(4);
    chk("standby entry", 1'b1, stby);
    wait_rise(DEAD + 40);
    wait_rise(DEAD + 40);
    chk_rng("standby dead time", DEAD, DEAD + 20, last_off);
    c895 <= 1'b0;
    cyc(4);
    chk("standby kept in band", 1'b1, stby);
    c913 <= 1'b1;
    cyc(4);
    chk("standby exit", 1'b0, stby);
    $display("test standby done");
  endtask
  // ----------------------------------------------------------------
  // verdict
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    miscompares++;
    $display("[FAIL] watchdog expected finish seen hang");
    report_and_stop();
  end
  initial begin
    t_start();
    t_switch();
    t_short();
    t_ovp();
    t_line();
    t_standby();
    report_and_stop();
  end
endmodule

// file: verif/vdps_stage_model.sv
// flyback power stage as the sequencer sees it through its comparators
`timescale 1ns/100ps
module vdps_stage_model (
  // clock
  input wire logic clock,
  // knobs from the bench
  input wire logic damped, // ringing too weak to show a valley
  input wire logic [7:0] on_len, // cycles to peak, 0 = never
  input wire logic [7:0] ring_len, // demag cycles before the valley
  // from the controller
  input wire logic gate_drive_output,
  // comparator results
  output logic valley_sense_input,
  output logic peak_reached,
  output logic sample_strobe
);
  logic drv_d; // drive one cycle ago
  int on_n; // cycles since drive rose
  int off_n; // cycles since drive fell
  initial begin
    drv_d = 1'b0;
    on_n = 0;
    off_n = 0;
    valley_sense_input = 1'b0;
    peak_reached = 1'b0;
    sample_strobe = 1'b0;
  end
  // one sample per switching cycle, just after the drive ends
  always @(posedge clock) begin
    drv_d <= gate_drive_output;
    sample_strobe <= drv_d & ~gate_drive_output;
  end
  // primary ramp: peak after on_len cycles, never if on_len is zero
  always @(posedge clock) begin
    on_n <= gate_drive_output ? on_n + 1 : 0;
    peak_reached <= gate_drive_output && on_len != 8'h00
      && on_n + 1 >= int'(on_len);
  end
  // aux winding: high while demagnetising, then falls into a valley;
  // the sense stays low while the switch conducts
  always @(posedge clock) begin
    off_n <= gate_drive_output ? 0 : off_n + 1;
    valley_sense_input <= !gate_drive_output && !damped
      && off_n < int'(ring_len);
  end
endmodule

// file: verilog/vdps_core.sv
// valley detection, protection timers and gate-drive sequencer
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/100ps
module vdps_core #(
  parameter int RECOVER_CYC = vdps_pkg::RECOVER_CYC,
  parameter int LOVP_RST_CYC = vdps_pkg::LOVP_RST_CYC,
  parameter int UVP_CYC = vdps_pkg::UVP_CYC,
  parameter int BO_OFF_CYC = vdps_pkg::BO_OFF_CYC,
  parameter int STARTUP_CYC = vdps_pkg::STARTUP_CYC,
  parameter int SOVP_PAUSE_CYC = vdps_pkg::SOVP_PAUSE_CYC,
  parameter int MIN_OFF_CYC = vdps_pkg::MIN_OFF_CYC,
  parameter int TIMEOUT_CYC = vdps_pkg::TIMEOUT_CYC,
  parameter int DT_W = 16, // dead-time count width
  parameter int ON_W = 10 // max on-time count width
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // valley sense comparators
  input wire logic valley_sense_input, // high while above 55 mV
  input wire logic below_short_detect, // below short_detect_threshold
  input wire logic above_first_ovp, // sample above first_overvoltage_level
  input wire logic above_115, // sample above 115% of reference
  input wire logic below_105, // sample below 105% of reference
  input wire logic above_second_ovp, // sample above 130% of reference
  input wire logic sample_strobe, // one pulse per cycle, sample valid
  // current sense and compensation
  input wire logic peak_reached, // current sense hit setpoint
  input wire logic comp_below_895, // compensation below 895 mV
  input wire logic comp_above_913, // compensation above 913 mV
  input wire logic [DT_W-1:0] dead_time_cycles, // mapped 700-913 mV span
  input wire logic [ON_W-1:0] max_on_cycles, // from scaled reference
  // line sense comparators
  input wire logic above_brownout_on, // above brownout_on_level
  input wire logic below_brownout_off, // below brownout_off_level
  input wire logic above_line_ovp, // above line_overvoltage_level
  input wire logic below_line_release, // below release level
  // outputs
  output logic gate_drive_output, // gate-drive request
  output logic feedforward_enable, // line offset on current sense
  output logic standby_active, // peak frozen at standby_peak_level
  output logic reduced_setpoint, // compensation scaled down
  output logic output_undervoltage_fault, // one-cycle fault pulse
  output logic overvoltage_fault // one-cycle fast ovp pulse
);
  localparam int CW = vdps_pkg::CNT_W;

  // ----------------------------------------------------------------
  // input registers
  // ----------------------------------------------------------------
  logic vs_r, vs_d_r, short_r, ovp1_r, hi115_r, lo105_r, ovp2_r, smp_r;
  logic peak_r, c895_r, c913_r, bon_r, boff_r, lovp_r, lrel_r;

  // inputs are synchronous; one register stage aligns them
  always_ff @(posedge clock) begin
    if (rst) begin
      vs_r <= 1'b1;
      vs_d_r <= 1'b1;
      {short_r, ovp1_r, hi115_r, lo105_r, ovp2_r, smp_r} <= '0;
      {peak_r, c895_r, c913_r, bon_r, boff_r, lovp_r, lrel_r} <= '0;
    end else begin
      vs_r <= valley_sense_input;
      vs_d_r <= vs_r;
      short_r <= below_short_detect;
      ovp1_r <= above_first_ovp;
      hi115_r <= above_115;
      lo105_r <= below_105;
      ovp2_r <= above_second_ovp;
      smp_r <= sample_strobe;
      peak_r <= peak_reached;
      c895_r <= comp_below_895;
      c913_r <= comp_above_913;
      bon_r <= above_brownout_on;
      boff_r <= below_brownout_off;
      lovp_r <= above_line_ovp;
      lrel_r <= below_line_release;
    end
  end

  // ----------------------------------------------------------------
  // duration timers
  // ----------------------------------------------------------------
  logic state_run;
  logic uvp_done, start_done, bo_done, lrel_done, to_done;
  logic off_phase;

  vdps_timer #(.W(CW)) u_uvp (.clock(clock), .rst(rst),
    .run(short_r && state_run), .limit(CW'(UVP_CYC)),
    .done(uvp_done));
  vdps_timer #(.W(CW)) u_start (.clock(clock), .rst(rst),
    .run(short_r), .limit(CW'(STARTUP_CYC)), .done(start_done));
  vdps_timer #(.W(CW)) u_bo (.clock(clock), .rst(rst),
    .run(boff_r), .limit(CW'(BO_OFF_CYC)), .done(bo_done));
  vdps_timer #(.W(CW)) u_lrel (.clock(clock), .rst(rst),
    .run(lrel_r), .limit(CW'(LOVP_RST_CYC)), .done(lrel_done));
  vdps_timer #(.W(CW)) u_to (.clock(clock), .rst(rst),
    .run(!vs_r && off_phase), .limit(CW'(TIMEOUT_CYC)),
    .done(to_done));

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  vdps_pkg::vdps_state_t state_r;
  logic [CW-1:0] wait_r; // recovery / pause counter
  logic [2:0] ovp1_cnt_r, ovp2_cnt_r; // consecutive sample counts
  logic slow_seen_r; // slow trip has happened
  logic restart_min_r; // restart after fault: min off if short
  logic fault_now, fast_trip;

  assign state_run = (state_r == vdps_pkg::VDPS_RUN) ||
                     (state_r == vdps_pkg::VDPS_SOVP);
  assign fast_trip = smp_r && ovp2_r &&
    (ovp2_cnt_r + 3'(1) >= (slow_seen_r ? 3'(vdps_pkg::OVP2_FAST)
                                        : 3'(vdps_pkg::OVP_CONSEC)));
  assign fault_now = uvp_done || fast_trip;

  // main sequencing; line faults take priority in every state except recovery, which ignores them
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= vdps_pkg::VDPS_OFF;
      wait_r <= '0;
      restart_min_r <= 1'b0;
    end else begin
      case (state_r)
        vdps_pkg::VDPS_OFF: begin
          if (lovp_r) begin
            state_r <= vdps_pkg::VDPS_LOVP;
          end else if (bon_r) begin
            state_r <= vdps_pkg::VDPS_RUN;
          end
        end
        vdps_pkg::VDPS_RUN, vdps_pkg::VDPS_SOVP: begin
          wait_r <= wait_r + CW'(1);
          if (lovp_r) begin
            state_r <= vdps_pkg::VDPS_LOVP;
          end else if (bo_done) begin
            state_r <= vdps_pkg::VDPS_OFF;
          end else if (fault_now) begin
            state_r <= vdps_pkg::VDPS_RECOVER;
            wait_r <= '0;
          end else if (state_r == vdps_pkg::VDPS_RUN) begin
            if (smp_r && ovp1_r &&
                ovp1_cnt_r == 3'(vdps_pkg::OVP_CONSEC - 1)) begin
              state_r <= vdps_pkg::VDPS_SOVP;
              wait_r <= '0;
            end
          end else if (smp_r && lo105_r) begin
            state_r <= vdps_pkg::VDPS_RUN;
          end else if (smp_r && hi115_r) begin
            wait_r <= '0; // new 1.4 ms period per re-sample
          end
        end
        vdps_pkg::VDPS_RECOVER: begin
          wait_r <= wait_r + CW'(1);
          if (wait_r == CW'(RECOVER_CYC - 1)) begin
            state_r <= vdps_pkg::VDPS_OFF;
            restart_min_r <= 1'b1;
          end
        end
        default: begin // line over-voltage: wait for clean release
          if (lrel_done) begin
            state_r <= vdps_pkg::VDPS_OFF;
          end
        end
      endcase
      if (restart_min_r && state_run && !short_r) begin
        restart_min_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // over-voltage counting
  // ----------------------------------------------------------------
  // counts reset on any sample under the level: consecutive only
  always_ff @(posedge clock) begin
    if (rst || !state_run) begin
      ovp1_cnt_r <= '0;
      ovp2_cnt_r <= '0;
      if (rst || state_r == vdps_pkg::VDPS_RECOVER) begin
        slow_seen_r <= 1'b0;
      end
    end else if (smp_r) begin
      ovp1_cnt_r <= ovp1_r ? ovp1_cnt_r + 3'(1) : '0;
      ovp2_cnt_r <= ovp2_r ? ovp2_cnt_r + 3'(1) : '0;
      if (state_r == vdps_pkg::VDPS_SOVP) begin
        slow_seen_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // standby hysteresis
  // ----------------------------------------------------------------
  logic stby_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      stby_r <= 1'b0;
    end else if (c913_r) begin
      stby_r <= 1'b0;
    end else if (c895_r) begin
      stby_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // switching cycle: on phase, then off phase with holds
  // ----------------------------------------------------------------
  logic drv_r;
  logic [ON_W-1:0] on_cnt_r;
  logic [CW-1:0] off_cnt_r; // cycles since drive fell
  logic valley_ev, hold_ok, min_off_need;

  assign off_phase = state_run && !drv_r;
  assign valley_ev = vs_d_r && !vs_r; // falling edge
  assign min_off_need = short_r && (start_done || restart_min_r);
  // every active hold must have expired before a new set
  assign hold_ok =
    (!min_off_need || off_cnt_r >= CW'(MIN_OFF_CYC)) &&
    (!stby_r || off_cnt_r >= CW'(dead_time_cycles)) &&
    (state_r != vdps_pkg::VDPS_SOVP ||
     wait_r >= CW'(SOVP_PAUSE_CYC));

  // drive latch: set by valley or time-out, reset by peak or max on
  always_ff @(posedge clock) begin
    if (rst || !state_run || lovp_r || fault_now) begin
      drv_r <= 1'b0;
      on_cnt_r <= '0;
      off_cnt_r <= '0;
    end else if (drv_r) begin
      on_cnt_r <= on_cnt_r + ON_W'(1);
      if (peak_r || on_cnt_r >= max_on_cycles) begin
        drv_r <= 1'b0;
        off_cnt_r <= '0;
      end
    end else begin
      if (off_cnt_r != '1) begin
        off_cnt_r <= off_cnt_r + CW'(1);
      end
      if ((valley_ev || to_done) && hold_ok) begin
        drv_r <= 1'b1; // time-out counts as a valley
        on_cnt_r <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic uvp_r, ovf_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      uvp_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      uvp_r <= state_run && uvp_done && !lovp_r && !bo_done;
      ovf_r <= state_run && fast_trip && !uvp_done;
    end
  end

  assign gate_drive_output = drv_r;
  assign feedforward_enable = drv_r; // on-time only, any load
  assign standby_active = stby_r;
  assign reduced_setpoint = (state_r == vdps_pkg::VDPS_SOVP);
  assign output_undervoltage_fault = uvp_r;
  assign overvoltage_fault = ovf_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_line_high;
    lovp_r;
  endsequence

  chk_line_stop: assert property (@(posedge clock) disable iff (rst)
    s_line_high |=> !gate_drive_output)
    else $error("drive active during line over-voltage");
  chk_ff_on_time: assert property (@(posedge clock) disable iff (rst)
    feedforward_enable == gate_drive_output)
    else $error("feed-forward outside on-time");
  chk_drive_hold: assert property (@(posedge clock) disable iff (rst)
    $rose(gate_drive_output) |-> $past(hold_ok))
    else $error("drive set during hold");
  chk_valley_edge: assert property (@(posedge clock) disable iff (rst)
    (off_phase && valley_ev && hold_ok && !lovp_r && !fault_now)
    |=> gate_drive_output)
    else $error("valley did not set drive");
  chk_stby_exit: assert property (@(posedge clock) disable iff (rst)
    c913_r |=> !standby_active)
    else $error("standby not left");
  chk_recover_off: assert property (@(posedge clock) disable iff (rst)
    state_r == vdps_pkg::VDPS_RECOVER |-> !gate_drive_output)
    else $error("drive in recovery");
  chk_uvp_entry: assert property (@(posedge clock) disable iff (rst)
    output_undervoltage_fault |-> state_r == vdps_pkg::VDPS_RECOVER)
    else $error("under-voltage fault without recovery");
  chk_max_on: assert property (@(posedge clock) disable iff (rst)
    (drv_r && on_cnt_r >= max_on_cycles) |=> !gate_drive_output)
    else $error("max on-time exceeded");
endmodule

// file: verilog/vdps_pkg.sv
// constants and types shared by the valley / protection sequencer
package vdps_pkg;
  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000; // core clock rate
  localparam int NS_PER_S = 1000000000;
  // ----------------------------------------------------------------
  // timing figures in their own units
  // ----------------------------------------------------------------
  localparam int TIMEOUT_NS = 6500; // valley time-out, 6.5 us
  localparam int MIN_OFF_US = 50; // start-up minimum off time
  localparam int STARTUP_MS = 8; // short level before min off applies
  localparam int UVP_MS = 90; // output under-voltage delay
  localparam int SOVP_PAUSE_US = 1400; // slow over-voltage pause 1.4 ms
  localparam int BO_OFF_MS = 25; // brown-out shutdown delay
  localparam int LOVP_RST_MS = 340; // line over-voltage release delay
  localparam int RECOVER_MS = 4000; // auto-recovery pause, 4 s
  // ----------------------------------------------------------------
  // derived cycle counts (least times round up, long ones down)
  // ----------------------------------------------------------------
  localparam int TIMEOUT_CYC = (TIMEOUT_NS * (CLK_HZ / 1000000)
    + 999) / 1000;
  localparam int MIN_OFF_CYC = MIN_OFF_US * (CLK_HZ / 1000000);
  localparam int SOVP_PAUSE_CYC = SOVP_PAUSE_US * (CLK_HZ / 1000000);
  localparam int STARTUP_CYC = STARTUP_MS * (CLK_HZ / 1000);
  localparam int UVP_CYC = UVP_MS * (CLK_HZ / 1000);
  localparam int BO_OFF_CYC = BO_OFF_MS * (CLK_HZ / 1000);
  localparam int LOVP_RST_CYC = LOVP_RST_MS * (CLK_HZ / 1000);
  localparam int RECOVER_CYC = RECOVER_MS * (CLK_HZ / 1000);
  // ----------------------------------------------------------------
  // over-voltage cycle counts
  // ----------------------------------------------------------------
  localparam int OVP_CONSEC = 4; // consecutive cycles, normal
  localparam int OVP2_FAST = 2; // cycles once slow trip has occurred
  localparam int CNT_W = 27; // counter width, holds 4 s
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    VDPS_OFF,     // brown-out or waiting for clean start
    VDPS_RUN,     // normal switching
    VDPS_SOVP,    // slow over-voltage pulsing
    VDPS_RECOVER, // auto-recovery pause
    VDPS_LOVP     // line over-voltage stop
  } vdps_state_t;
endpackage

// file: verilog/vdps_timer.sv
// saturating level-duration timer with a terminal flag
`timescale 1ns/100ps
module vdps_timer #(
  parameter int W = 27
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic run, // counts while high, clears when low
  input wire logic [W-1:0] limit, // count at which done rises
  // status
  output logic done // level: run held for limit cycles
);
  logic [W-1:0] cnt_r; // elapsed cycles

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // saturates so a long level never wraps back to zero
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      cnt_r <= '0;
    end else if (cnt_r != limit) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  assign done = run && (cnt_r == limit);
endmodule
